// File: host_model.sv
// Host controller model issuing one status command per call.
// Assumes the device takes a command at a rising edge with valid high.
`timescale 1ns/100ps
module host_model (
    input  wire        clk_in,
    output reg         valid_out,
    output reg  [3:0]  code_out,
    output reg  [15:0] data_out
);
    initial begin
        valid_out = 1'b0;
        code_out  = 4'h0;
        data_out  = 16'h0;
    end
    // Masks go out as weighted sums; held across the taking edge
    task send(input [3:0] c, input [15:0] d);
        begin
            @(negedge clk_in);
            valid_out = 1'b1;
            code_out  = c;
            data_out  = d;
            @(negedge clk_in);
            valid_out = 1'b0;
            code_out  = ~c; // Junk when idle, so a stale value never passes
            data_out  = ~d;
        end
    endtask
endmodule // host_model

// File: status_map.vh
// Constants for the instrument status reporting block.
// Assumes inclusion by bare name from the status design files.
`ifndef STATUS_MAP_VH
`define STATUS_MAP_VH

// Status byte bit positions
`define STB_QUES_BIT      3
`define STB_ESB_BIT       5
`define STB_MSS_BIT       6

// Standard event bit positions
`define ESR_OPC_BIT       0
`define ESR_QYE_BIT       2
`define ESR_DDE_BIT       3
`define ESR_EXE_BIT       4
`define ESR_CME_BIT       5
`define ESR_PON_BIT       7
`define ESR_USED_MASK     8'hbd

// Questionable group bit positions
`define QUES_VOLT_BIT     0
`define QUES_UNLOCK_BIT   5
`define QUES_CAL_BIT      8
`define QUES_EXTREF_BIT   9
`define QUES_USED_MASK    16'h0321

// Reset values
`define PSC_RESET         1'b1
`define SRE_RESET         8'h00
`define ESE_RESET         8'h00
`define QUES_EN_RESET     16'h0000
`define OPER_EN_RESET     16'h0000
`define ESR_RESET         8'h80

// Command codes on the command port
`define CMD_NONE          4'h0
`define CMD_READ_STB      4'h1
`define CMD_WRITE_SRE     4'h2
`define CMD_READ_SRE      4'h3
`define CMD_READ_QCOND    4'h4
`define CMD_READ_QEVENT   4'h5
`define CMD_WRITE_QEN     4'h6
`define CMD_READ_QEN      4'h7
`define CMD_READ_ESR      4'h8
`define CMD_WRITE_ESE     4'h9
`define CMD_READ_ESE      4'ha
`define CMD_CLS           4'hb
`define CMD_PRESET        4'hc
`define CMD_WRITE_PSC     4'hd
`define CMD_READ_PSC      4'he
`define CMD_OPC           4'hf

`endif

// File: status_nvstore.v
// Small retained store for the two enable masks and the power-on clear setting.
// Assumes the keep-alive domain outlives the instrument reset on RST_N_IN.
`timescale 1ns/100ps
`include "status_map.vh"

module status_nvstore (
    input  wire       clk_in,
    input  wire       wr_in,
    input  wire [7:0] wr_sre_in,
    input  wire [7:0] wr_ese_in,
    input  wire       wr_psc_in,
    output reg  [7:0] sre_out,
    output reg  [7:0] ese_out,
    output reg        psc_out,
    output reg        valid_out
);
    // No reset here: contents survive the instrument reset; valid marks first fill
    always @(posedge clk_in) begin
        if (wr_in) begin
            sre_out   <= wr_sre_in;
            ese_out   <= wr_ese_in;
            psc_out   <= wr_psc_in;
            valid_out <= 1'b1;
        end
    end
endmodule // status_nvstore

// File: status_reporting.v
// Status byte, questionable and standard-event groups of a remote instrument.
// Assumes commands come from same-clock parser logic; condition and event inputs are pins.
`timescale 1ns/100ps
`include "status_map.vh"

// Summary of operation
// - Status byte read returns poll value without clearing the master summary bit.
// - Master summary ORs enabled status byte bits; rising selection raises service request.
// - Clear status zeroes event registers but keeps every enable mask.
// - With setting 0, service and event enable masks survive power cycles.
// - Questionable condition is read-only, live, and not cleared by reading.
// - Questionable event bits latch until read or clear status.
// - Enabled questionable events form the status byte questionable summary.
// - Status preset clears questionable and operation enable masks.
// - Standard event bits latch; cleared on read or clear status.
// - Enabled standard events form status byte bit 5 summary.
// - Status preset leaves the service request enable mask alone.
// - Clear status also empties error queue and cancels pending completion.
// - Setting 1 zeroes event enable and service request enable at power-up; default 1.
// - Completion bit set only after all earlier commands finish.
// - Reads return the weighted sum of bits currently set.
// - Standard event weights 1,4,8,16,32,128; others read zero in the event register.
// - Questionable weights 1,32,256,512; others read zero in condition and event reads.
module status_reporting (
    input  wire        MCLK_IN,
    input  wire        RST_N_IN,
    input  wire        CMD_VALID_IN,
    input  wire [3:0]  CMD_CODE_IN,
    input  wire [15:0] CMD_DATA_IN,
    input  wire        CMDS_IDLE_IN,
    input  wire [15:0] QUES_COND_IN,
    input  wire        QUERY_ERR_IN,
    input  wire        DEVICE_ERR_IN,
    input  wire        EXEC_ERR_IN,
    input  wire        CMD_ERR_IN,
    input  wire        ERR_QUEUE_NONEMPTY_IN,
    input  wire        MAV_IN,
    output reg  [15:0] RD_DATA_OUT,
    output reg         RD_VALID_OUT,
    output reg  [7:0]  STATUS_BYTE_OUT,
    output reg         SRQ_OUT,
    output reg         ERR_QUEUE_CLEAR_OUT,
    output reg  [15:0] OPER_EN_OUT
);
    // Two-flop synchronisers for pin-side levels
    // Only the second stage feeds logic, so a metastable first stage never fans out
    reg [15:0] qcond_s1, qcond;
    reg [3:0]  err_s1, err_s2;
    reg        idle_s1, idle;
    reg        eq_s1, eq;
    reg        mav_s1, mav;
    reg [3:0]  err_prev;
    always @(posedge MCLK_IN) begin
        qcond_s1 <= QUES_COND_IN;
        qcond    <= qcond_s1;
        err_s1   <= {CMD_ERR_IN, EXEC_ERR_IN, DEVICE_ERR_IN, QUERY_ERR_IN};
        err_s2   <= err_s1;
        idle_s1  <= CMDS_IDLE_IN;
        idle     <= idle_s1;
        eq_s1    <= ERR_QUEUE_NONEMPTY_IN;
        eq       <= eq_s1;
        mav_s1   <= MAV_IN;
        mav      <= mav_s1;
        err_prev <= err_s2;
    end

    reg [7:0]  sre, ese, esr;
    reg [15:0] ques_en, ques_evt, qcond_prev, oper_en;
    reg        psc, opc_pending, por_done, mss_prev;
    wire [7:0] nv_sre, nv_ese;
    wire       nv_psc, nv_valid;

    // Commands decoded once
    wire cmd_cls    = CMD_VALID_IN && (CMD_CODE_IN == `CMD_CLS);
    wire cmd_preset = CMD_VALID_IN && (CMD_CODE_IN == `CMD_PRESET);
    wire rd_esr     = CMD_VALID_IN && (CMD_CODE_IN == `CMD_READ_ESR);
    wire rd_qevt    = CMD_VALID_IN && (CMD_CODE_IN == `CMD_READ_QEVENT);

    // Query codes answered on the read port; gates both valid and data
    function is_query;
        input [3:0] code;
        begin
            is_query = (code == `CMD_READ_STB)   || (code == `CMD_READ_SRE)
                    || (code == `CMD_READ_QCOND) || (code == `CMD_READ_QEVENT)
                    || (code == `CMD_READ_QEN)   || (code == `CMD_READ_ESR)
                    || (code == `CMD_READ_ESE)   || (code == `CMD_READ_PSC);
        end
    endfunction
    wire rd_any     = CMD_VALID_IN && is_query(CMD_CODE_IN);

    // Summaries; operational summary not modelled here
    wire ques_sum = |(ques_evt & ques_en);
    wire esb_sum  = |(esr & ese);

    // Status byte without bit 6, then master summary
    function [7:0] stb_base;
        input e, m, q, s;
        begin
            stb_base = 8'h00;
            stb_base[2] = e;
            stb_base[4] = m;
            stb_base[`STB_QUES_BIT] = q;
            stb_base[`STB_ESB_BIT]  = s;
        end
    endfunction
    wire [7:0] stb_nomss = stb_base(eq, mav, ques_sum, esb_sum);
    wire       mss       = |(stb_nomss & sre & 8'hbf);
    wire [7:0] stb       = stb_nomss | {1'b0, mss, 6'h00};

    // Retained copy of masks; the retained setting decides whether it is used
    status_nvstore u_nv (
        .clk_in    (MCLK_IN),
        .wr_in     (por_done),
        .wr_sre_in (sre),
        .wr_ese_in (ese),
        .wr_psc_in (psc),
        .sre_out   (nv_sre),
        .ese_out   (nv_ese),
        .psc_out   (nv_psc),
        .valid_out (nv_valid)
    );

    // Enable masks and setting; setting restored after reset, sre and ese too when it was 0
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            sre      <= `SRE_RESET;
            ese      <= `ESE_RESET;
            ques_en  <= `QUES_EN_RESET;
            oper_en  <= `OPER_EN_RESET;
            psc      <= `PSC_RESET;
            por_done <= 1'b0;
        end else begin
            por_done <= 1'b1;
            // First cycle after release; an unfilled store falls through to commands
            if (!por_done && nv_valid) begin
                psc <= nv_psc;
                if (!nv_psc) begin
                    sre <= nv_sre;
                    ese <= nv_ese;
                end
            end else if (CMD_VALID_IN) begin
                case (CMD_CODE_IN)
                    `CMD_WRITE_SRE: sre <= CMD_DATA_IN[7:0] & 8'hbf;
                    `CMD_WRITE_ESE: ese <= CMD_DATA_IN[7:0];
                    `CMD_WRITE_QEN: ques_en <= CMD_DATA_IN;
                    `CMD_WRITE_PSC: psc <= CMD_DATA_IN[0];
                    `CMD_PRESET: begin
                        ques_en <= 16'h0000;             // sre untouched
                        oper_en <= 16'h0000;
                    end
                    default: ;                           // Clear status keeps masks
                endcase
            end
        end
    end

    // Event latches; a new event wins over a same-cycle clear
    wire [15:0] ques_rise = qcond & ~qcond_prev & `QUES_USED_MASK;
    wire [7:0]  err_rise  = {2'b00, err_s2 & ~err_prev, 2'b00};
    wire        opc_fire  = opc_pending && idle;
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            qcond_prev  <= 16'h0000;
            ques_evt    <= 16'h0000;
            esr         <= `ESR_RESET;                   // Power-on event after reset
            opc_pending <= 1'b0;
        end else begin
            qcond_prev <= qcond;
            ques_evt <= ((rd_qevt || cmd_cls) ? 16'h0000 : ques_evt) | ques_rise;
            esr <= (((rd_esr || cmd_cls) ? 8'h00 : esr)
                    | err_rise | {7'h00, opc_fire}) & `ESR_USED_MASK;
            if (cmd_cls)
                opc_pending <= 1'b0;
            else if (CMD_VALID_IN && CMD_CODE_IN == `CMD_OPC)
                opc_pending <= 1'b1;
            else if (opc_fire)
                opc_pending <= 1'b0;
        end
    end

    // Query answers, one cycle after the command; data stand until the next query
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            RD_DATA_OUT  <= 16'h0000;
            RD_VALID_OUT <= 1'b0;
        end else begin
            RD_VALID_OUT <= rd_any;
            // Idle command lines never disturb the last answer
            if (rd_any) begin
                case (CMD_CODE_IN)
                    `CMD_READ_STB:    RD_DATA_OUT <= {8'h00, stb};
                    `CMD_READ_SRE:    RD_DATA_OUT <= {8'h00, sre};
                    `CMD_READ_QCOND:  RD_DATA_OUT <= qcond & `QUES_USED_MASK;
                    `CMD_READ_QEVENT: RD_DATA_OUT <= ques_evt;
                    `CMD_READ_QEN:    RD_DATA_OUT <= ques_en;
                    `CMD_READ_ESR:    RD_DATA_OUT <= {8'h00, esr};
                    `CMD_READ_ESE:    RD_DATA_OUT <= {8'h00, ese};
                    `CMD_READ_PSC:    RD_DATA_OUT <= {15'h0000, psc};
                    default:          RD_DATA_OUT <= RD_DATA_OUT;
                endcase
            end
        end
    end

    // Status byte, service request edge and error queue clear strobe
    always @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            STATUS_BYTE_OUT     <= 8'h00;               // Cleared at power-up
            SRQ_OUT             <= 1'b0;
            mss_prev            <= 1'b0;
            ERR_QUEUE_CLEAR_OUT <= 1'b0;
            OPER_EN_OUT         <= 16'h0000;
        end else begin
            STATUS_BYTE_OUT     <= stb;                  // Reads never touch bit 6
            mss_prev            <= mss;
            SRQ_OUT             <= mss && !mss_prev;
            ERR_QUEUE_CLEAR_OUT <= cmd_cls;
            OPER_EN_OUT         <= oper_en;
        end
    end
endmodule // status_reporting

// File: status_reporting_monitor.sv
// Port-level checker for the status reporting block.
// Assumes it is bound into status_reporting and sees only its ports.
`timescale 1ns/100ps
module status_reporting_monitor (
    input wire        MCLK_IN,
    input wire        RST_N_IN,
    input wire        CMD_VALID_IN,
    input wire [3:0]  CMD_CODE_IN,
    input wire [15:0] RD_DATA_OUT,
    input wire        RD_VALID_OUT,
    input wire [7:0]  STATUS_BYTE_OUT,
    input wire        SRQ_OUT,
    input wire        ERR_QUEUE_CLEAR_OUT,
    input wire [15:0] OPER_EN_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Codes as in the command header; the first cycle after reset is ignored
    wire [3:0] c = CMD_CODE_IN;
    wire rd = CMD_VALID_IN && (c == 4'h1 || c == 4'h3 || c == 4'h4 || c == 4'h5 ||
              c == 4'h7 || c == 4'h8 || c == 4'ha || c == 4'he);
    a_read_answers: assert property ((rd && $past(RST_N_IN)) |=> RD_VALID_OUT) else $error("read unanswered");
    a_other_silent: assert property (!rd |=> !RD_VALID_OUT) else $error("answer without read");
    a_esr_weights: assert property ((CMD_VALID_IN && c == 4'h8 && $past(RST_N_IN))
        |=> (RD_DATA_OUT & 16'hff42) == 16'h0) else $error("unused event bit set");
    a_ques_weights: assert property ((CMD_VALID_IN && (c == 4'h4 || c == 4'h5) && $past(RST_N_IN))
        |=> (RD_DATA_OUT & 16'hfcde) == 16'h0) else $error("unused ques bit set");
    a_psc_boolean: assert property ((CMD_VALID_IN && c == 4'he && $past(RST_N_IN))
        |=> RD_DATA_OUT[15:1] == 15'h0) else $error("setting not 0 or 1");
    a_srq_on_rise: assert property ($rose(STATUS_BYTE_OUT[6]) |-> ##[0:2] SRQ_OUT) else $error("no request");
    a_srq_one_pulse: assert property (SRQ_OUT |=> !SRQ_OUT) else $error("request too long");
    a_cls_empties_queue: assert property ((CMD_VALID_IN && c == 4'hb && $past(RST_N_IN))
        |-> ##[1:2] ERR_QUEUE_CLEAR_OUT) else $error("queue not emptied");
    a_preset_oper: assert property ((CMD_VALID_IN && c == 4'hc && $past(RST_N_IN))
        |-> ##2 OPER_EN_OUT == 16'h0) else $error("operation mask kept");
    a_oper_holds: assert property (!(CMD_VALID_IN && c == 4'hc) |=> ##1 $stable(OPER_EN_OUT)) else $error("mask moved");
    // Main scenarios reached
    c_srq: cover property (SRQ_OUT);
    c_clear: cover property (ERR_QUEUE_CLEAR_OUT);
    c_opc: cover property (CMD_VALID_IN && c == 4'hf);
endmodule // status_reporting_monitor
bind status_reporting status_reporting_monitor mon (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .CMD_VALID_IN(CMD_VALID_IN), .CMD_CODE_IN(CMD_CODE_IN), .RD_DATA_OUT(RD_DATA_OUT),
    .RD_VALID_OUT(RD_VALID_OUT), .STATUS_BYTE_OUT(STATUS_BYTE_OUT), .SRQ_OUT(SRQ_OUT),
    .ERR_QUEUE_CLEAR_OUT(ERR_QUEUE_CLEAR_OUT), .OPER_EN_OUT(OPER_EN_OUT));

// File: testbench.sv
// Self-checking bench for the status reporting block.
// Assumes host_model issues commands; the bench drives the status pins.
`timescale 1ns/100ps
`include "status_map.vh"
module testbench;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         idle = 1'b1;
    reg  [15:0] cond = 16'h0;
    reg  [3:0]  errs = 4'h0;
    wire        v, rdv, srq, eqc;
    wire [3:0]  code;
    wire [15:0] data, rd, oper;
    wire [7:0]  stb;
    integer     n_fail = 0;
    integer     n_checks = 0;
    integer     srqs = 0;
    integer     clrs = 0;
    host_model host (.clk_in(mclk), .valid_out(v), .code_out(code), .data_out(data));
    status_reporting DUT (.MCLK_IN(mclk), .RST_N_IN(rst_n), .CMD_VALID_IN(v), .CMD_CODE_IN(code),
        .CMD_DATA_IN(data), .CMDS_IDLE_IN(idle), .QUES_COND_IN(cond), .QUERY_ERR_IN(errs[0]),
        .DEVICE_ERR_IN(errs[1]), .EXEC_ERR_IN(errs[2]), .CMD_ERR_IN(errs[3]),
        .ERR_QUEUE_NONEMPTY_IN(1'b0), .MAV_IN(1'b0), .RD_DATA_OUT(rd), .RD_VALID_OUT(rdv),
        .STATUS_BYTE_OUT(stb), .SRQ_OUT(srq), .ERR_QUEUE_CLEAR_OUT(eqc), .OPER_EN_OUT(oper));
    initial forever #5 mclk = ~mclk;
    // Pulse counters, so a short pulse is never missed between checks
    always @(posedge mclk) begin
        if (srq === 1'b1) srqs = srqs + 1;
        if (eqc === 1'b1) clrs = clrs + 1;
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Query, then look at the answer half a cycle after it was taken, while it stands
    task rq(input [3:0] c, input [15:0] exp);
        begin
            host.send(c, 16'h0);
            chk({15'h0, rdv}, 16'h1);
            chk(rd, exp);
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge mclk);
    endtask
    // Two edges after release, since the first one restores retained masks
    task rst;
        begin
            rst_n = 1'b0;
            wt(20);
            rst_n = 1'b1;
            wt(2);
        end
    endtask
    task tally_and_finish;
        begin
            if (n_fail == 0 && n_checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
    initial begin
        rst;
        rq(`CMD_READ_ESR, 16'h0080);
        rq(`CMD_READ_ESR, 16'h0000);
        rq(`CMD_READ_PSC, 16'h0001);
        host.send(`CMD_WRITE_SRE, 16'h0028);
        host.send(`CMD_WRITE_ESE, 16'h0010);
        host.send(`CMD_WRITE_QEN, 16'h0020);
        rq(`CMD_READ_SRE, 16'h0028);
        rq(`CMD_READ_ESE, 16'h0010);
        rq(`CMD_READ_QEN, 16'h0020);
        // Bit 1 is unused and must not show
        cond = 16'h0003;
        errs = 4'h1;
        wt(6);
        rq(`CMD_READ_QCOND, 16'h0001);
        rq(`CMD_READ_QCOND, 16'h0001);
        rq(`CMD_READ_QEVENT, 16'h0001);
        rq(`CMD_READ_QEVENT, 16'h0000);
        rq(`CMD_READ_ESR, 16'h0004);
        chk({8'h0, stb}, 16'h0000);
        cond = 16'h0023;
        wt(6);
        chk({8'h0, stb}, 16'h0048);
        chk(srqs, 16'h1);
        rq(`CMD_READ_STB, 16'h0048);
        rq(`CMD_READ_STB, 16'h0048);
        errs = 4'h5;
        wt(6);
        chk({8'h0, stb}, 16'h0068);
        chk(srqs, 16'h1);
        rq(`CMD_READ_QEVENT, 16'h0020);
        wt(4);
        chk({8'h0, stb}, 16'h0060);
        host.send(`CMD_CLS, 16'h0);
        wt(4);
        chk(clrs, 16'h1);
        chk({8'h0, stb}, 16'h0000);
        rq(`CMD_READ_ESR, 16'h0000);
        rq(`CMD_READ_SRE, 16'h0028);
        rq(`CMD_READ_ESE, 16'h0010);
        rq(`CMD_READ_QEN, 16'h0020);
        host.send(`CMD_PRESET, 16'h0);
        rq(`CMD_READ_QEN, 16'h0000);
        rq(`CMD_READ_SRE, 16'h0028);
        chk(oper, 16'h0000);
        // Completion waits for idle; clear status cancels a pending one
        cond = 16'h0;
        errs = 4'h0;
        idle = 1'b0;
        wt(6);
        host.send(`CMD_OPC, 16'h0);
        wt(5);
        rq(`CMD_READ_ESR, 16'h0000);
        idle = 1'b1;
        wt(5);
        rq(`CMD_READ_ESR, 16'h0001);
        idle = 1'b0;
        wt(4);
        host.send(`CMD_OPC, 16'h0);
        host.send(`CMD_CLS, 16'h0);
        idle = 1'b1;
        wt(5);
        rq(`CMD_READ_ESR, 16'h0000);
        host.send(`CMD_WRITE_PSC, 16'h0);
        rq(`CMD_READ_PSC, 16'h0000);
        rst;
        rq(`CMD_READ_SRE, 16'h0028);
        rq(`CMD_READ_ESE, 16'h0010);
        host.send(`CMD_WRITE_PSC, 16'h1);
        rst;
        rq(`CMD_READ_ESE, 16'h0000);
        chk({8'h0, stb}, 16'h0000);
        tally_and_finish;
    end
endmodule // testbench
